/* tsf_pkg.sv */
package tsf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned UV_FILT_NS     = 40000;  // undervoltage_filter_time
  localparam int unsigned GTS_HOLD_NS    = 20000;  // go-to-sleep dwell
  localparam int unsigned UV_FILT_CYC    = UV_FILT_NS / CLK_PERIOD_NS;
  localparam int unsigned GTS_HOLD_CYC   = (GTS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 12;
  localparam logic [2:0]  EDGE_LIMIT     = 3'h4;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_STATUS     = 12'h000;
  localparam logic [11:0] REG_CONTROL    = 12'h004;
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0001;
  localparam int unsigned CTRL_FAULT_EN  = 0;
  localparam int unsigned STAT_MODE_LSB  = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_NORMAL  = 5'b00001,
    MODE_SILENT  = 5'b00010,
    MODE_STANDBY = 5'b00100,
    MODE_GOSLEEP = 5'b01000,
    MODE_SLEEP   = 5'b10000
  } tsf_mode_t;

  typedef struct packed {
    logic bus_fault_flag;
    logic battery_undervoltage_flag;
    logic io_supply_undervoltage_flag;
    logic core_supply_undervoltage_flag;
    logic inhibit_mask_change_flag;
    logic wake_source_local;
    logic wake_source_flag;
    logic wake_request_flag;
    logic cold_start_flag;
  } tsf_flags_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tsf_apb_req_t;

endpackage

/* tsf_sync3.sv */
`timescale 1ns/1ps
module tsf_sync3 import tsf_pkg::*; (
  input  wire logic ref_clk_i,   // core clock
  input  wire logic resetn_i,    // async reset, active low
  input  wire logic rst_val_i,   // value taken one edge after reset release
  input  wire logic async_i,     // pin level
  output logic      sync_o       // filtered level
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;
  logic init_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ff1_r <= 1'b0;
      ff2_r <= 1'b0;
      ff3_r <= 1'b0;
    end else if (!init_r) begin
      // Prime the chain so no false change follows reset
      ff1_r <= rst_val_i;
      ff2_r <= rst_val_i;
      ff3_r <= rst_val_i;
    end else begin
      ff1_r <= async_i;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end

  // Change counts only once two later stages agree
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_r <= 1'b0;
      sync_o <= 1'b0;
    end else if (!init_r) begin
      init_r <= 1'b1;
      sync_o <= rst_val_i;
    end else if (ff2_r == ff3_r) begin
      sync_o <= ff3_r;
    end
  end
endmodule

/* tsf_uv_filter.sv */
`timescale 1ns/1ps
module tsf_uv_filter import tsf_pkg::*; (
  input  wire logic ref_clk_i,   // core clock
  input  wire logic resetn_i,    // async reset, active low
  input  wire logic uv_i,        // synchronised comparator, high = below threshold
  input  wire logic restart_i,   // restart the filter time
  output logic      qual_o       // undervoltage held for the full filter time
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r  <= '0;
      qual_o <= 1'b0;
    end else if (!uv_i || restart_i) begin
      cnt_r  <= '0;
      qual_o <= 1'b0;
    end else if (cnt_r == CNT_W'(UV_FILT_CYC - 1)) begin
      qual_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + CNT_W'(1);
    end
  end
endmodule

/* tsf_status_core.sv */
// Notes on behaviour
// - Battery power-up or recovery sets cold-start, wake-request and local wake-source.
// - Silent entered from standby or sleep with cold-start set drives fault low.
// - Cold-start clears only on a transition into normal mode.
// - Wake request sets on a wake only in standby, go-to-sleep, sleep; restarts UV filters.
// - Standby entered with wake request set drives fault and receive low.
// - Wake request clears on normal entry or core/IO undervoltage.
// - Go-to-sleep is refused while wake request is set.
// - Wake source sets on bus wake, local wake edge or power-up.
// - Wake source keeps the first source until cleared or a battery recovery sets local.
// - In normal, wake source shows fault low for local, high for bus.
// - Wake source clears after four TX falling edges, leaving normal, or UV.
// - Inhibit-mask change sets a flag shown as fault low in silent.
// - Inhibit-mask change flag clears entering normal, standby, go-to-sleep or sleep.
// - Core/IO undervoltage flags set below, clear on recovery or wake; not shown.
// - Battery undervoltage flag set below, clear on recovery, causes cold start.
// - Bus fault flag sets after fault persists four TX rising edges.
// - Bus fault drives fault low only in normal mode.
// - Bus fault clears leaving normal or after four clean TX rising edges.
`timescale 1ns/1ps
module tsf_status_core import tsf_pkg::*; (
  input  wire logic        ref_clk_i,       // 25 MHz core clock
  input  wire logic        resetn_i,        // cold start reset, active low
  input  wire logic        psel_i,          // APB select
  input  wire logic        penable_i,       // APB enable
  input  wire logic        pwrite_i,        // APB direction
  input  wire logic [11:0] paddr_i,         // APB byte address
  input  wire logic [31:0] pwdata_i,        // APB write data
  output logic      [31:0] prdata_o,        // APB read data
  output logic             pready_o,        // APB ready
  output logic             pslverr_o,       // APB error
  input  wire logic        en_i,            // mode pin
  input  wire logic        stb_n_i,         // mode pin, active low standby
  input  wire logic        txd_i,           // transmit input, low = dominant
  input  wire logic        inhibit_mask_input_i, // mask pin
  input  wire logic        sup_uv_i,        // battery comparator, high = low supply
  input  wire logic        cc_uv_i,         // core supply comparator
  input  wire logic        io_uv_i,         // IO supply comparator
  input  wire logic        bus_err_i,       // bus short detector, same clock
  input  wire logic        bus_wake_i,      // remote wake pulse, same clock
  input  wire logic        local_wake_i,    // local wake pulse, same clock
  input  wire logic        rx_bus_i,        // receiver data, same clock
  output logic             fault_n_o,       // fault_indicator_output level
  output logic             fault_oe_o,      // fault pin drive enable
  output logic             rxd_o,           // receive output
  output logic             inh_en_o         // inhibit function enabled
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic en_s, stb_n_s, txd_dom_s, mask_s, sup_uv_s, cc_uv_s, io_uv_s;

  tsf_sync3 u_en   (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(en_i), .sync_o(en_s));
  tsf_sync3 u_stb  (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(stb_n_i), .sync_o(stb_n_s));
  tsf_sync3 u_txd  (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(!txd_i), .sync_o(txd_dom_s));
  tsf_sync3 u_mask (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(inhibit_mask_input_i), .sync_o(mask_s));
  tsf_sync3 u_sup  (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(sup_uv_i), .sync_o(sup_uv_s));
  tsf_sync3 u_cc   (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(cc_uv_i), .sync_o(cc_uv_s));
  tsf_sync3 u_io   (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .rst_val_i(1'b0),
                    .async_i(io_uv_i), .sync_o(io_uv_s));

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  tsf_mode_t        mode_r;
  tsf_mode_t        mode_nxt;
  tsf_flags_t       flg_r;
  logic [CNT_W-1:0] gts_cnt_r;
  logic             wake_ev;
  logic             sup_rec;
  logic             cold_ev;
  logic             cc_q, io_q;
  logic             uv_q;
  logic             enter_normal, leave_normal, changed;

  assign wake_ev = bus_wake_i | local_wake_i;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_SLEEP: begin
        if (flg_r.wake_request_flag) begin
          mode_nxt = MODE_STANDBY;
        end else if (stb_n_s) begin
          mode_nxt = en_s ? MODE_NORMAL : MODE_SILENT;
        end
      end
      MODE_GOSLEEP: begin
        if (!(en_s && !stb_n_s)) begin
          mode_nxt = stb_n_s ? MODE_SILENT : MODE_STANDBY;
        end else if (gts_cnt_r == CNT_W'(GTS_HOLD_CYC - 1)) begin
          mode_nxt = MODE_SLEEP;
        end
      end
      MODE_NORMAL, MODE_SILENT, MODE_STANDBY: begin
        if (stb_n_s) begin
          mode_nxt = en_s ? MODE_NORMAL : MODE_SILENT;
        end else if (en_s && !flg_r.wake_request_flag) begin
          mode_nxt = MODE_GOSLEEP;
        end else begin
          mode_nxt = MODE_STANDBY;
        end
      end
    endcase
  end

  assign changed      = mode_nxt != mode_r;
  assign enter_normal = changed && mode_nxt == MODE_NORMAL;
  assign leave_normal = changed && mode_r == MODE_NORMAL;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= MODE_STANDBY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gts_cnt_r <= '0;
    end else if (mode_r != MODE_GOSLEEP) begin
      gts_cnt_r <= '0;
    end else if (gts_cnt_r != CNT_W'(GTS_HOLD_CYC - 1)) begin
      gts_cnt_r <= gts_cnt_r + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Supply monitoring
  // ----------------------------------------------------------------
  logic set_wake_req;
  assign set_wake_req = wake_ev && (mode_r inside {MODE_STANDBY, MODE_GOSLEEP, MODE_SLEEP});

  // Filters restart whenever a wake event raises a wake request
  tsf_uv_filter u_ccf (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .uv_i(cc_uv_s),
                       .restart_i(set_wake_req), .qual_o(cc_q));
  tsf_uv_filter u_iof (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .uv_i(io_uv_s),
                       .restart_i(set_wake_req), .qual_o(io_q));

  assign uv_q    = cc_q | io_q;
  assign sup_rec = flg_r.battery_undervoltage_flag && !sup_uv_s;
  assign cold_ev = sup_rec;

  // ----------------------------------------------------------------
  // Transmit edge counting
  // ----------------------------------------------------------------
  logic       txd_d_r, tx_fall, tx_rise, err_seen_r;
  logic [2:0] src_cnt_r, bf_cnt_r, ok_cnt_r;

  // Dominant level is low in reset and idle alike, so no false edge
  assign tx_fall = !txd_d_r && txd_dom_s;
  assign tx_rise = txd_d_r && !txd_dom_s;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txd_d_r    <= 1'b0;
      err_seen_r <= 1'b0;
    end else begin
      txd_d_r <= txd_dom_s;
      if (tx_rise || !txd_dom_s) begin
        err_seen_r <= 1'b0;
      end else if (bus_err_i) begin
        err_seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_cnt_r <= '0;
      bf_cnt_r  <= '0;
      ok_cnt_r  <= '0;
    end else if (mode_r != MODE_NORMAL) begin
      src_cnt_r <= '0;
      bf_cnt_r  <= '0;
      ok_cnt_r  <= '0;
    end else begin
      if (tx_fall && src_cnt_r != EDGE_LIMIT) begin
        src_cnt_r <= src_cnt_r + 3'h1;
      end
      if (tx_rise && err_seen_r) begin
        bf_cnt_r <= (bf_cnt_r == EDGE_LIMIT) ? EDGE_LIMIT : bf_cnt_r + 3'h1;
        ok_cnt_r <= '0;
      end else if (tx_rise) begin
        ok_cnt_r <= (ok_cnt_r == EDGE_LIMIT) ? EDGE_LIMIT : ok_cnt_r + 3'h1;
        bf_cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic mask_lat_r;
  logic silent_lowpwr_r;
  logic src_done;
  assign src_done = mode_r == MODE_NORMAL && tx_fall && src_cnt_r == EDGE_LIMIT - 3'h1;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flg_r                   <= '0;
      flg_r.cold_start_flag   <= 1'b1;
      flg_r.wake_request_flag <= 1'b1;
      flg_r.wake_source_flag  <= 1'b1;
      flg_r.wake_source_local <= 1'b1;
    end else begin
      if (cold_ev) begin
        flg_r.cold_start_flag <= 1'b1;
      end else if (enter_normal) begin
        flg_r.cold_start_flag <= 1'b0;
      end
      if (cold_ev || set_wake_req) begin
        flg_r.wake_request_flag <= 1'b1;
      end else if (enter_normal || uv_q) begin
        flg_r.wake_request_flag <= 1'b0;
      end
      if (cold_ev) begin
        flg_r.wake_source_flag  <= 1'b1;
        flg_r.wake_source_local <= 1'b1;
      end else if (wake_ev && !flg_r.wake_source_flag) begin
        flg_r.wake_source_flag  <= 1'b1;
        flg_r.wake_source_local <= local_wake_i;
      end else if (src_done || leave_normal || uv_q) begin
        flg_r.wake_source_flag  <= 1'b0;
      end
      if (mask_s != mask_lat_r && mode_r == MODE_SILENT && !changed) begin
        flg_r.inhibit_mask_change_flag <= 1'b1;
      end else if (changed && mode_nxt != MODE_SILENT) begin
        flg_r.inhibit_mask_change_flag <= 1'b0;
      end
      if (cc_q) begin
        flg_r.core_supply_undervoltage_flag <= 1'b1;
      end else if (!cc_uv_s || set_wake_req) begin
        flg_r.core_supply_undervoltage_flag <= 1'b0;
      end
      if (io_q) begin
        flg_r.io_supply_undervoltage_flag <= 1'b1;
      end else if (!io_uv_s || set_wake_req) begin
        flg_r.io_supply_undervoltage_flag <= 1'b0;
      end
      flg_r.battery_undervoltage_flag <= sup_uv_s;
      if (mode_r == MODE_NORMAL && tx_rise && err_seen_r && !leave_normal &&
          bf_cnt_r == EDGE_LIMIT - 3'h1) begin
        flg_r.bus_fault_flag <= 1'b1;
      end else if (leave_normal || (mode_r == MODE_NORMAL && tx_rise && !err_seen_r &&
                                    ok_cnt_r == EDGE_LIMIT - 3'h1)) begin
        flg_r.bus_fault_flag <= 1'b0;
      end
    end
  end

  // Latched mask survives mode changes, lost only with the battery
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_lat_r <= 1'b0;
    end else if (sup_uv_s) begin
      mask_lat_r <= 1'b0;
    end else if (mode_r == MODE_SILENT && !changed) begin
      mask_lat_r <= mask_s;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      silent_lowpwr_r <= 1'b0;
    end else if (changed && mode_nxt == MODE_SILENT) begin
      silent_lowpwr_r <= mode_r inside {MODE_STANDBY, MODE_SLEEP};
    end
  end

  // ----------------------------------------------------------------
  // Pin indication
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic        ind_any, ind_rx;

  always_comb begin
    ind_any = 1'b0;
    ind_rx  = 1'b0;
    unique case (mode_r)
      MODE_NORMAL: begin
        ind_any = (flg_r.wake_source_flag && flg_r.wake_source_local)
                | flg_r.bus_fault_flag;
      end
      MODE_SILENT: begin
        ind_any = (flg_r.cold_start_flag && silent_lowpwr_r)
                | flg_r.inhibit_mask_change_flag;
      end
      MODE_STANDBY: begin
        ind_any = flg_r.wake_request_flag;
        ind_rx  = flg_r.wake_request_flag;
      end
      MODE_GOSLEEP, MODE_SLEEP: begin
        ind_any = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_n_o  <= 1'b1;
      fault_oe_o <= 1'b0;
      rxd_o      <= 1'b1;
      inh_en_o   <= 1'b1;
    end else begin
      fault_n_o  <= !(ind_any && ctrl_r[CTRL_FAULT_EN]);
      fault_oe_o <= mode_r != MODE_SLEEP;
      rxd_o      <= ind_rx ? 1'b0 : rx_bus_i;
      inh_en_o   <= !mask_lat_r && mode_r != MODE_SLEEP;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  tsf_apb_req_t req;
  logic         setup_ph;
  logic [31:0]  status_w;

  assign req      = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
  assign setup_ph = req.psel && !req.penable;
  assign status_w = {11'h000, mode_r, 7'h00, flg_r};

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= setup_ph;
      pslverr_o <= setup_ph && req.paddr != REG_STATUS && req.paddr != REG_CONTROL;
      prdata_o  <= '0;
      if (setup_ph && !req.pwrite) begin
        if (req.paddr == REG_STATUS) begin
          prdata_o <= status_w;
        end else if (req.paddr == REG_CONTROL) begin
          prdata_o <= ctrl_r;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= CONTROL_RESET;
    end else if (req.psel && req.penable && pready_o && req.pwrite &&
                 req.paddr == REG_CONTROL) begin
      ctrl_r <= {31'h0000_0000, req.pwdata[CTRL_FAULT_EN]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_enter_normal;
    mode_r != MODE_NORMAL ##1 mode_r == MODE_NORMAL;
  endsequence

  chk_cold_clear_normal: assert property (s_enter_normal |-> !flg_r.cold_start_flag)
    else $error("cold start flag survived normal entry");
  chk_cold_on_recovery: assert property (sup_rec |=> flg_r.cold_start_flag &&
                                         flg_r.wake_request_flag && flg_r.wake_source_local)
    else $error("battery recovery did not cold start");
  chk_wake_req_mode: assert property ($rose(flg_r.wake_request_flag) |->
                                      $past(mode_r) != MODE_NORMAL && $past(mode_r) != MODE_SILENT
                                      || $past(sup_rec))
    else $error("wake request set in wrong mode");
  chk_no_gosleep_wake: assert property (flg_r.wake_request_flag && mode_r == MODE_STANDBY
                                        |=> mode_r != MODE_GOSLEEP)
    else $error("go-to-sleep taken with wake request");
  chk_standby_wake_pins: assert property (mode_r == MODE_STANDBY && flg_r.wake_request_flag
                                          && ctrl_r[CTRL_FAULT_EN] |=> !fault_n_o && !rxd_o)
    else $error("standby wake not shown on pins");
  chk_source_kept: assert property (flg_r.wake_source_flag && !sup_rec
                                    |=> $stable(flg_r.wake_source_local))
    else $error("wake source overwritten");
  chk_source_leave: assert property (leave_normal && !wake_ev && !sup_rec
                                     |=> !flg_r.wake_source_flag)
    else $error("wake source kept after leaving normal");
  chk_bus_fault_mode: assert property (mode_r != MODE_NORMAL && !flg_r.inhibit_mask_change_flag
                                       && !(flg_r.cold_start_flag && silent_lowpwr_r)
                                       && !flg_r.wake_request_flag |=> fault_n_o)
    else $error("fault shown outside its mode");
  chk_bus_fault_leave: assert property (leave_normal |=> !flg_r.bus_fault_flag)
    else $error("bus fault kept after leaving normal");
  chk_sleep_release: assert property (mode_r == MODE_SLEEP |=> !fault_oe_o)
    else $error("fault pin driven in sleep");
  chk_mask_flag_clear: assert property (changed && mode_nxt == MODE_STANDBY
                                        |=> !flg_r.inhibit_mask_change_flag)
    else $error("mask change flag kept");
endmodule

/* tsf_ctrl_model.sv */
`timescale 1ns/1ps
module tsf_ctrl_model (
  input  wire logic ref_clk_i,  // core clock
  input  wire logic fault_n_i,  // fault pin level as seen on the board
  output logic      en_o,       // mode pin
  output logic      stb_n_o,    // mode pin, active low standby
  output logic      txd_o,      // transmit, low = dominant
  output logic      mask_o      // inhibit mask pin
);
  initial begin
    en_o = 1'b0;
    stb_n_o = 1'b0;
    txd_o = 1'b1;
    mask_o = 1'b0;
  end
  task automatic set_mode(input logic stb_n, input logic en);
    @(posedge ref_clk_i);
    stb_n_o <= stb_n;
    en_o <= en;
  endtask
  // Long bits so the pin synchronisers see every level
  task automatic send_bit();
    @(posedge ref_clk_i);
    txd_o <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    txd_o <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
  endtask
  // A released pin is not high, so it never counts as a clean fault line
  task automatic set_mask(input logic v, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge ref_clk_i);
      ok = (fault_n_i === 1'b1);
    end
    if (ok)
      mask_o <= v;
  endtask
endmodule

/* test_transceiver_status_flag_logic.sv */
`timescale 1ns/1ps
module test_transceiver_status_flag_logic import tsf_pkg::*; ;
  typedef struct {logic stb_n; logic en; logic mask; logic [31:0] st; logic fn;} tsf_row_t;
  logic         ref_clk_i, resetn_i, bus_err_i, bus_wake_i, local_wake_i, e, ok;
  logic         sup_uv, cc_uv, io_uv;
  logic         pready_o, pslverr_o, fault_n_o, fault_oe_o, rxd_o, inh_en_o;
  logic  [31:0] prdata_o, q;
  wire logic    en, stb_n, txd, mask, fault_pin;
  tsf_apb_req_t req;
  int           failures, tests_run;
  tsf_row_t     rows [5] = '{'{1, 0, 0, 32'h0002_000F, 0}, '{1, 1, 0, 32'h0001_000C, 0},
    '{1, 0, 0, 32'h0002_0008, 1}, '{1, 0, 1, 32'h0002_0018, 0}, '{1, 1, 1, 32'h0001_0008, 1}};
  assign fault_pin = fault_oe_o ? fault_n_o : 1'bz;
  tsf_status_core DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(req.psel),
    .penable_i(req.penable), .pwrite_i(req.pwrite), .paddr_i(req.paddr), .pwdata_i(req.pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .en_i(en), .stb_n_i(stb_n),
    .txd_i(txd), .inhibit_mask_input_i(mask), .sup_uv_i(sup_uv), .cc_uv_i(cc_uv), .io_uv_i(io_uv),
    .bus_err_i(bus_err_i), .bus_wake_i(bus_wake_i), .local_wake_i(local_wake_i),
    .rx_bus_i(1'b1), .fault_n_o(fault_n_o), .fault_oe_o(fault_oe_o), .rxd_o(rxd_o),
    .inh_en_o(inh_en_o));
  tsf_ctrl_model PM (.ref_clk_i(ref_clk_i), .fault_n_i(fault_pin), .en_o(en), .stb_n_o(stb_n),
    .txd_o(txd), .mask_o(mask));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] x);
    tests_run++;
    if (got !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    q = prdata_o;
    e = pslverr_o;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", q, x);
  endtask
  task automatic pulse(input logic remote);
    @(posedge ref_clk_i);
    bus_wake_i <= remote;
    local_wake_i <= !remote;
    @(posedge ref_clk_i);
    bus_wake_i <= 1'b0;
    local_wake_i <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    resetn_i = 1'b0;
    {bus_err_i, bus_wake_i, local_wake_i, sup_uv, cc_uv, io_uv} = 6'h00;
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(REG_STATUS, 32'h0004_000F);
    rd(REG_CONTROL, CONTROL_RESET);
    apb(1'b1, REG_CONTROL, 32'h0000_0000);
    rd(REG_CONTROL, 32'h0000_0000);
    apb(1'b1, REG_CONTROL, CONTROL_RESET);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
    foreach (rows[i]) begin
      if (rows[i].mask !== mask) begin
        PM.set_mask(rows[i].mask, ok);
        chk("mask_ack", {31'h0, ok}, 32'h0000_0001);
      end
      PM.set_mode(rows[i].stb_n, rows[i].en);
      repeat (12) @(posedge ref_clk_i);
      rd(REG_STATUS, rows[i].st);
      chk("fault_pin", {31'h0, fault_pin}, {31'h0, rows[i].fn});
    end
    PM.set_mode(1'b0, 1'b0);
    repeat (12) @(posedge ref_clk_i);
    PM.set_mode(1'b0, 1'b1);
    repeat (540) @(posedge ref_clk_i);
    chk("fault_oe", {31'h0, fault_oe_o}, 32'h0000_0000);
    pulse(1'b1);
    repeat (10) @(posedge ref_clk_i);
    chk("wake_pins", {30'h0, fault_pin, rxd_o}, 32'h0000_0000);
    rd(REG_STATUS, 32'h0004_0006);
    pulse(1'b0);
    repeat (10) @(posedge ref_clk_i);
    rd(REG_STATUS, 32'h0004_0006);
    PM.set_mode(1'b1, 1'b1);
    repeat (12) @(posedge ref_clk_i);
    chk("fault_pin", {31'h0, fault_pin}, 32'h0000_0001);
    for (int k = 1; k <= 4; k++) begin
      PM.send_bit();
      rd(REG_STATUS, (k < 4) ? 32'h0001_0004 : 32'h0001_0000);
    end
    for (int k = 1; k <= 8; k++) begin
      bus_err_i <= (k <= 4);
      PM.send_bit();
      repeat (4) @(posedge ref_clk_i);
      rd(REG_STATUS, (k >= 4 && k < 8) ? 32'h0001_0100 : 32'h0001_0000);
      chk("fault_pin", {31'h0, fault_pin}, {31'h0, !(k >= 4 && k < 8)});
    end
    chk("inh_en", {31'h0, inh_en_o}, 32'h0000_0000);
    sup_uv <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    rd(REG_STATUS, 32'h0001_0080);
    chk("inh_en", {31'h0, inh_en_o}, 32'h0000_0001);
    sup_uv <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rd(REG_STATUS, 32'h0001_000F);
    chk("fault_pin", {31'h0, fault_pin}, 32'h0000_0000);
    {cc_uv, io_uv} <= 2'b11;
    repeat (1020) @(posedge ref_clk_i);
    rd(REG_STATUS, 32'h0001_0069);
    chk("fault_pin", {31'h0, fault_pin}, 32'h0000_0001);
    {cc_uv, io_uv} <= 2'b00;
    repeat (12) @(posedge ref_clk_i);
    rd(REG_STATUS, 32'h0001_0009);
    // Mid-run cold start with the pins still asking for normal mode
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(REG_STATUS, 32'h0004_000F);
    repeat (12) @(posedge ref_clk_i);
    rd(REG_STATUS, 32'h0001_000C);
    report_and_stop();
  end
endmodule
